// ===== core/wdpf_pkg.sv
// constants shared by the watchdog / power-fail supervisor and its guard
// assumes one 25 MHz crystal clock and 8-bit special function registers
package wdpf_pkg;

  // register addresses on the special function register port
  localparam logic [7:0] ADDR_CLOCK_CONTROL    = 8'h8E;
  localparam logic [7:0] ADDR_EXT_FLAGS        = 8'h91;
  localparam logic [7:0] ADDR_TIMED_ACCESS     = 8'hC7;
  localparam logic [7:0] ADDR_WATCHDOG_CONTROL = 8'hD8;
  localparam logic [7:0] ADDR_EXT_IRQ_ENABLE   = 8'hE8;

  // timed access keys
  localparam logic [7:0] TA_KEY_FIRST  = 8'hAA;
  localparam logic [7:0] TA_KEY_SECOND = 8'h55;

  // watchdog_control fields
  localparam int WDC_RESTART  = 0;
  localparam int WDC_ARM      = 1;
  localparam int WDC_WATCHDOG_RESET_FLAG     = 2;
  localparam int WDC_WATCHDOG_IRQ_FLAG     = 3;
  localparam int WDC_PFI_FLAG = 4;
  localparam int WDC_PFI_EN   = 5;
  localparam int WDC_POR_FLAG = 6;
  // clock_control, extended_irq_enable, extended flags fields
  localparam int CKC_SEL_LO   = 6;
  localparam int CKC_SEL_HI   = 7;
  localparam int EIE_WDT_EN   = 4;
  localparam int EXF_BANDGAP  = 0;

  // reset values
  localparam logic [7:0] CLOCK_CONTROL_RESET = 8'h01;
  localparam logic [7:0] EXT_IRQ_EN_RESET    = 8'h00;

  // timing
  localparam int CLOCKS_PER_MCYCLE = 4;
  localparam int TA_WINDOW_MCYCLES = 3;
  localparam logic [3:0] TA_WINDOW_CLOCKS =
    4'(CLOCKS_PER_MCYCLE * TA_WINDOW_MCYCLES);
  localparam int WD_CNT_W = 27;
  localparam logic [WD_CNT_W-1:0] WD_RESET_DELAY = 27'h0000200;
  localparam logic [3:0] WD_RESET_PULSE = 4'h8;
  localparam int POR_CNT_W = 17;

  // interrupt vectors
  localparam logic [15:0] VECTOR_NONE = 16'h0000;
  localparam logic [15:0] VECTOR_PFI  = 16'h0033;
  localparam logic [15:0] VECTOR_WDT  = 16'h0063;

  typedef enum logic [2:0] {
    TA_IDLE  = 3'b001,
    TA_ARMED = 3'b010,
    TA_OPEN  = 3'b100
  } ta_state_t;

endpackage

// ===== core/ta_if.sv
// carrier between the supervisor and its timed-access guard
// assumes both ends share one clock
`timescale 1ns/1ns
interface ta_if;
  logic       wr;
  logic [7:0] addr;
  logic [7:0] data;
  logic       consume;
  logic       open;
  modport guard (input wr, input addr, input data, input consume,
                 output open);
  modport core  (output wr, output addr, output data, output consume,
                 input open);
endinterface

// ===== core/ta_guard.sv
// timed-access guard: opens a short write window after the key pair
// assumes register writes arrive as single-cycle strobes
`timescale 1ns/1ns
module ta_guard (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  // register side
  ta_if.guard       ta
);

  wdpf_pkg::ta_state_t state_q;
  wdpf_pkg::ta_state_t state_d;
  logic [3:0]          win_q;
  logic [3:0]          win_d;
  logic                key_wr;

  assign key_wr = ta.wr && (ta.addr == wdpf_pkg::ADDR_TIMED_ACCESS);

  // the armed state also times out, so a stray first key cannot linger
  always_comb begin
    state_d = state_q;
    win_d   = win_q;
    unique case (state_q)
      wdpf_pkg::TA_IDLE: begin
        if (key_wr && ta.data == wdpf_pkg::TA_KEY_FIRST) begin
          state_d = wdpf_pkg::TA_ARMED;
          win_d   = wdpf_pkg::TA_WINDOW_CLOCKS;
        end
      end
      wdpf_pkg::TA_ARMED: begin
        win_d = win_q - 4'h1;
        if (key_wr && ta.data == wdpf_pkg::TA_KEY_SECOND) begin
          state_d = wdpf_pkg::TA_OPEN; // [RQ10]
          win_d   = wdpf_pkg::TA_WINDOW_CLOCKS;
        end else if (key_wr && ta.data == wdpf_pkg::TA_KEY_FIRST) begin
          win_d = wdpf_pkg::TA_WINDOW_CLOCKS;
        end else if (key_wr || win_q == 4'h1) begin
          state_d = wdpf_pkg::TA_IDLE;
        end
      end
      wdpf_pkg::TA_OPEN: begin
        win_d = win_q - 4'h1;
        if (ta.consume || win_q == 4'h1) begin
          state_d = wdpf_pkg::TA_IDLE; // [RQ10]
        end
      end
      default: begin
        state_d = wdpf_pkg::TA_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= wdpf_pkg::TA_IDLE;
      win_q   <= 4'h0;
    end else begin
      state_q <= state_d;
      win_q   <= win_d;
    end
  end

  assign ta.open = (state_q == wdpf_pkg::TA_OPEN);

  a_ta_open_entry: assert property ( // [RQ10]
    @(posedge i_clk) disable iff (!i_rst_n)
    $rose(ta.open) |-> $past(key_wr && ta.data == wdpf_pkg::TA_KEY_SECOND))
    else $error("guard opened without the second key");

endmodule

// ===== core/wdpf_supervisor.sv
// watchdog timer and power-fail supervisor behind the register port
// assumes supply comparators are asynchronous; register strobes are on i_clk
//
// How it works
// RQ1: watchdog counts crystal clocks, one count per clock edge.
// RQ2: select field picks interrupt point of 2^17, 2^20, 2^23 or 2^26.
// RQ3: reset follows exactly 512 clocks after the interrupt point.
// RQ4: watchdog interrupt flag sets at the interrupt point.
// RQ5: watchdog reset flag records a watchdog-caused reset.
// RQ6: arm bit enables the watchdog; disarmed it neither interrupts nor resets.
// RQ7: restart bit clears the count for a fresh full interval.
// RQ8: software must restart before the interval expires.
// RQ9: arm and restart writes count only inside the timed-access window.
// RQ10: keys AAh then 55h at C7h open a three-cycle window.
// RQ11: interrupt flag, power-on flag, band-gap select also need the window.
// RQ12: software should restart before changing the select field.
// RQ13: watchdog interrupt reaches the CPU only when its enable is set.
// RQ14: hold reset while supply low, then count 65536 clocks.
// RQ15: reset stays asserted while supply is below the reset level.
// RQ16: power-fail interrupt enable; taken request vectors to 0033h.
// RQ17: power-fail flag sets on every warning; software clears it.
// RQ18: enabled power-fail interrupt outranks every other source.
// RQ19: arming starts from zero and any reset clears the count.
`timescale 1ns/1ns
module wdpf_supervisor #(
  parameter int POR_STRETCH_CYCLES = 65536,
  parameter int WD_TIMEOUT_0       = 131072,
  parameter int WD_TIMEOUT_1       = 1048576,
  parameter int WD_TIMEOUT_2       = 8388608,
  parameter int WD_TIMEOUT_3       = 67108864
) (
  // crystal clock and power-on reset
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  // special function register port
  input  wire logic [7:0]  i_sfr_addr,
  input  wire logic        i_sfr_wr,
  input  wire logic        i_sfr_rd,
  input  wire logic [7:0]  i_sfr_wdata,
  output logic      [7:0]  o_sfr_rdata,
  // supply comparators
  input  wire logic        i_supply_below_reset,
  input  wire logic        i_supply_below_warning,
  // to the CPU core
  output logic             o_cpu_reset,
  output logic             o_wdt_irq,
  output logic             o_pfi_irq,
  output logic      [15:0] o_irq_vector,
  output logic             o_bandgap_keep
);

  localparam int W  = wdpf_pkg::WD_CNT_W;
  localparam int PW = wdpf_pkg::POR_CNT_W;

  // reset release
  logic rst_s1_q;
  logic rst_n;
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_s1_q <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n    <= rst_s1_q;
    end
  end

  // comparator synchronisers: a change counts when stages two and three agree
  logic [1:0] cmp_s1_q, cmp_s2_q, cmp_s3_q, cmp_q, cmp_d;
  always_comb begin
    cmp_d = cmp_q;
    if (cmp_s2_q == cmp_s3_q) begin
      cmp_d = cmp_s3_q;
    end
  end
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmp_s1_q <= 2'h3;
      cmp_s2_q <= 2'h3;
      cmp_s3_q <= 2'h3;
      cmp_q    <= 2'h3;
    end else begin
      cmp_s1_q <= {i_supply_below_warning, i_supply_below_reset};
      cmp_s2_q <= cmp_s1_q;
      cmp_s3_q <= cmp_s2_q;
      cmp_q    <= cmp_d;
    end
  end
  logic low_reset, low_warn;
  assign low_reset = cmp_q[0];
  assign low_warn  = cmp_q[1];

  function automatic logic [W-1:0] wd_limit(input logic [1:0] sel);
    unique case (sel)
      2'h0:    wd_limit = W'(WD_TIMEOUT_0);
      2'h1:    wd_limit = W'(WD_TIMEOUT_1);
      2'h2:    wd_limit = W'(WD_TIMEOUT_2);
      default: wd_limit = W'(WD_TIMEOUT_3);
    endcase
  endfunction

  // timed-access guard
  ta_if ta ();
  ta_guard u_guard (
    .i_clk   (i_clk),
    .i_rst_n (rst_n),
    .ta      (ta)
  );

  logic wr_wdc, wr_ckc, wr_eie, wr_exf, prot_ok;
  assign wr_wdc  = i_sfr_wr && i_sfr_addr == wdpf_pkg::ADDR_WATCHDOG_CONTROL;
  assign wr_ckc  = i_sfr_wr && i_sfr_addr == wdpf_pkg::ADDR_CLOCK_CONTROL;
  assign wr_eie  = i_sfr_wr && i_sfr_addr == wdpf_pkg::ADDR_EXT_IRQ_ENABLE;
  assign wr_exf  = i_sfr_wr && i_sfr_addr == wdpf_pkg::ADDR_EXT_FLAGS;
  assign prot_ok = ta.open;
  assign ta.wr      = i_sfr_wr;
  assign ta.addr    = i_sfr_addr;
  assign ta.data    = i_sfr_wdata;
  assign ta.consume = prot_ok && (wr_wdc || wr_exf);

  // state
  logic [7:0]            ckc_q, ckc_d, eie_q, eie_d, rdata_d;
  logic                  arm_q, arm_d, watchdog_irq_flag_q, watchdog_irq_flag_d, watchdog_reset_flag_q, watchdog_reset_flag_d;
  logic                  pfen_q, pfen_d, pflag_q, pflag_d;
  logic                  por_q, por_d, bgs_q, bgs_d;
  logic [W-1:0]          cnt_q, cnt_d, lim;
  logic [wdpf_pkg::POR_CNT_W-1:0] porc_q, porc_d;
  logic                  pbusy_q, pbusy_d;
  logic [3:0]            wdp_q, wdp_d;
  logic                  restart, fire, reset_d, wirq_d, pirq_d;
  logic [15:0]           vec_d;

  assign lim     = wd_limit(ckc_q[wdpf_pkg::CKC_SEL_HI:wdpf_pkg::CKC_SEL_LO]);
  assign restart = wr_wdc && prot_ok && i_sfr_wdata[wdpf_pkg::WDC_RESTART];
  assign fire    = arm_q && !o_cpu_reset
                   && cnt_q == lim + wdpf_pkg::WD_RESET_DELAY; // [RQ3] [RQ6]

  always_comb begin
    ckc_d = ckc_q;
    eie_d = eie_q;
    arm_d = arm_q;
    watchdog_irq_flag_d = watchdog_irq_flag_q;
    watchdog_reset_flag_d = watchdog_reset_flag_q;
    pfen_d = pfen_q;
    pflag_d = pflag_q;
    por_d = por_q;
    bgs_d = bgs_q;
    cnt_d = cnt_q;
    porc_d = porc_q;
    pbusy_d = pbusy_q;
    wdp_d = wdp_q;
    // supply hold and power-up stretch
    if (low_reset) begin
      pbusy_d = 1'b1; // [RQ15]
      porc_d  = '0;
    end else if (pbusy_q) begin
      if (porc_q == PW'(POR_STRETCH_CYCLES - 1)) begin
        pbusy_d = 1'b0; // [RQ14]
      end else begin
        porc_d = porc_q + 1'b1;
      end
    end
    if (fire) begin
      wdp_d = wdpf_pkg::WD_RESET_PULSE;
    end else if (wdp_q != 4'h0) begin
      wdp_d = wdp_q - 4'h1;
    end
    if (o_cpu_reset) begin
      // clock_control, enables and watchdog arm, interrupt flag and count return to reset values
      ckc_d = wdpf_pkg::CLOCK_CONTROL_RESET;
      eie_d = wdpf_pkg::EXT_IRQ_EN_RESET;
      arm_d = 1'b0;
      watchdog_irq_flag_d = 1'b0;
      pfen_d = 1'b0;
      bgs_d = 1'b0;
      cnt_d = '0; // [RQ19]
    end else begin
      if (wr_ckc) ckc_d = i_sfr_wdata;
      if (wr_eie) eie_d = i_sfr_wdata;
      if (wr_wdc) begin
        pfen_d = i_sfr_wdata[wdpf_pkg::WDC_PFI_EN]; // [RQ16]
        watchdog_reset_flag_d = i_sfr_wdata[wdpf_pkg::WDC_WATCHDOG_RESET_FLAG];
        pflag_d = i_sfr_wdata[wdpf_pkg::WDC_PFI_FLAG]; // [RQ17]
        if (prot_ok) begin
          arm_d  = i_sfr_wdata[wdpf_pkg::WDC_ARM]; // [RQ9]
          watchdog_irq_flag_d = i_sfr_wdata[wdpf_pkg::WDC_WATCHDOG_IRQ_FLAG]; // [RQ11]
          por_d  = i_sfr_wdata[wdpf_pkg::WDC_POR_FLAG]; // [RQ11]
        end
      end
      if (wr_exf && prot_ok) bgs_d = i_sfr_wdata[wdpf_pkg::EXF_BANDGAP];
      // one count per crystal clock, no machine-cycle prescale
      // disarming clears at once, so no stale count shows while disarmed
      if (!arm_q || !arm_d || restart || fire) begin
        cnt_d = '0; // [RQ7] [RQ19] [RQ6]
      end else begin
        cnt_d = cnt_q + 1'b1; // [RQ1]
      end
      if (arm_q && cnt_q == lim) watchdog_irq_flag_d = 1'b1; // [RQ4] [RQ2]
    end
    // hardware sets win over software clears
    if (low_warn) pflag_d = 1'b1; // [RQ17]
    if (fire) watchdog_reset_flag_d = 1'b1; // [RQ5]
    if (pbusy_q) begin
      watchdog_reset_flag_d = 1'b0;
      por_d  = 1'b1;
    end
    reset_d = pbusy_d || (wdp_d != 4'h0);
    // the CPU core takes the power-fail request ahead of any other source
    pirq_d = pflag_d && pfen_d && !reset_d; // [RQ18]
    wirq_d = watchdog_irq_flag_d && eie_d[wdpf_pkg::EIE_WDT_EN] && !reset_d; // [RQ13]
    vec_d = pirq_d ? wdpf_pkg::VECTOR_PFI :
            (wirq_d ? wdpf_pkg::VECTOR_WDT : wdpf_pkg::VECTOR_NONE); // [RQ16]
    rdata_d = o_sfr_rdata;
    if (i_sfr_rd) begin
      unique case (i_sfr_addr)
        wdpf_pkg::ADDR_CLOCK_CONTROL:  rdata_d = ckc_q;
        wdpf_pkg::ADDR_EXT_IRQ_ENABLE: rdata_d = eie_q;
        wdpf_pkg::ADDR_EXT_FLAGS:      rdata_d = {7'h00, bgs_q};
        wdpf_pkg::ADDR_WATCHDOG_CONTROL:
          rdata_d = {1'b0, por_q, pfen_q, pflag_q, watchdog_irq_flag_q, watchdog_reset_flag_q, arm_q, 1'b0};
        default:                       rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      ckc_q <= wdpf_pkg::CLOCK_CONTROL_RESET;
      eie_q <= wdpf_pkg::EXT_IRQ_EN_RESET;
      arm_q <= 1'b0;
      watchdog_irq_flag_q <= 1'b0;
      watchdog_reset_flag_q <= 1'b0;
      pfen_q <= 1'b0;
      pflag_q <= 1'b0;
      por_q <= 1'b1;
      bgs_q <= 1'b0;
      cnt_q <= '0;
      porc_q <= '0;
      pbusy_q <= 1'b1;
      wdp_q <= 4'h0;
      o_cpu_reset <= 1'b1;
      o_wdt_irq <= 1'b0;
      o_pfi_irq <= 1'b0;
      o_irq_vector <= wdpf_pkg::VECTOR_NONE;
      o_sfr_rdata <= 8'h00;
      o_bandgap_keep <= 1'b0;
    end else begin
      ckc_q <= ckc_d;
      eie_q <= eie_d;
      arm_q <= arm_d;
      watchdog_irq_flag_q <= watchdog_irq_flag_d;
      watchdog_reset_flag_q <= watchdog_reset_flag_d;
      pfen_q <= pfen_d;
      pflag_q <= pflag_d;
      por_q <= por_d;
      bgs_q <= bgs_d;
      cnt_q <= cnt_d;
      porc_q <= porc_d;
      pbusy_q <= pbusy_d;
      wdp_q <= wdp_d;
      o_cpu_reset <= reset_d;
      o_wdt_irq <= wirq_d;
      o_pfi_irq <= pirq_d;
      o_irq_vector <= vec_d;
      o_sfr_rdata <= rdata_d;
      o_bandgap_keep <= bgs_d;
    end
  end

  sequence s_wd_fire;
    fire ##1 o_cpu_reset;
  endsequence

  a_wd_irq_point: assert property ( // [RQ4]
    @(posedge i_clk) disable iff (!rst_n)
    (arm_q && !o_cpu_reset && cnt_q == lim) |=> watchdog_irq_flag_q)
    else $error("interrupt flag missed the interrupt point");
  a_wd_reset_delay: assert property ( // [RQ3]
    @(posedge i_clk) disable iff (!rst_n)
    fire |-> $past(cnt_q, wdpf_pkg::WD_RESET_DELAY)
             == cnt_q - wdpf_pkg::WD_RESET_DELAY)
    else $error("watchdog reset not 512 clocks after interrupt point");
  a_wd_reset_flag: assert property ( // [RQ5]
    @(posedge i_clk) disable iff (!rst_n)
    s_wd_fire |-> watchdog_reset_flag_q ##1 (!arm_q && o_cpu_reset))
    else $error("watchdog reset not recorded or too short");
  a_disarm_quiet: assert property ( // [RQ6]
    @(posedge i_clk) disable iff (!rst_n)
    !arm_q |-> !fire && cnt_q == '0)
    else $error("disarmed watchdog is counting");
  a_restart_clears: assert property ( // [RQ7]
    @(posedge i_clk) disable iff (!rst_n)
    (restart && !o_cpu_reset) |=> cnt_q == '0)
    else $error("restart did not clear the count");
  a_guard_blocks: assert property ( // [RQ9]
    @(posedge i_clk) disable iff (!rst_n)
    (wr_wdc && !prot_ok && !o_cpu_reset) |=> arm_q == $past(arm_q))
    else $error("unguarded write changed the arm bit");
  a_wdt_irq_gate: assert property ( // [RQ13]
    @(posedge i_clk) disable iff (!rst_n)
    o_wdt_irq |-> eie_q[wdpf_pkg::EIE_WDT_EN] && watchdog_irq_flag_q)
    else $error("watchdog interrupt passed while disabled");
  a_supply_hold: assert property ( // [RQ15]
    @(posedge i_clk) disable iff (!rst_n)
    low_reset |=> o_cpu_reset ##1 o_cpu_reset)
    else $error("reset released while supply low");
  a_pfi_flag_set: assert property ( // [RQ17]
    @(posedge i_clk) disable iff (!rst_n)
    low_warn |=> pflag_q)
    else $error("power-fail flag not set on warning");
  a_pfi_first: assert property ( // [RQ18]
    @(posedge i_clk) disable iff (!rst_n)
    o_pfi_irq |-> o_irq_vector == wdpf_pkg::VECTOR_PFI && pfen_q)
    else $error("power-fail request not given top precedence");

endmodule

// ===== bench/supply_model.sv
// supply comparator model for the supervisor bench
// assumes levels change just after a rising edge of i_clk
`timescale 1ns/1ns
module supply_model (
  // crystal clock
  input  wire logic i_clk,
  // comparator outputs, high means supply below level
  output logic      o_below_reset,
  output logic      o_below_warning
);
  // supply is low at time zero
  initial begin
    o_below_reset   = 1'b1;
    o_below_warning = 1'b1;
  end

  // warning level sits above reset level, so a deep drop warns too
  task automatic set_levels(input logic rst_lvl, input logic warn_lvl);
    @(posedge i_clk);
    #1;
    o_below_reset   = rst_lvl;
    o_below_warning = warn_lvl | rst_lvl;
  endtask
endmodule

// ===== bench/testbench.sv
// self-checking bench for the watchdog / power-fail supervisor
// assumes shortened counts: stretch 16, timeouts 64, 128, 256, 512
`timescale 1ns/1ns
module testbench;
  logic        clk;
  logic        nrst;
  logic        wr;
  logic        rd;
  logic        bsr;
  logic        bsw;
  logic [7:0]  addr;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic [7:0]  v;
  logic [7:0]  d;
  logic        cpu_reset;
  logic        wdt_irq;
  logic        pfi_irq;
  logic        bg_keep;
  logic [15:0] vec;
  int          num_errors;
  int          tests_run;
  int          seed;
  int          n;
  int          m;
  int          off0;
  logic [7:0]  ra [5] = '{8'h8E, 8'hD8, 8'hE8, 8'h91, 8'h90};
  logic [7:0]  rv [5] = '{8'h01, 8'h50, 8'h00, 8'h00, 8'h00};

  wdpf_supervisor #(
    .POR_STRETCH_CYCLES (16),
    .WD_TIMEOUT_0       (64),
    .WD_TIMEOUT_1       (128),
    .WD_TIMEOUT_2       (256),
    .WD_TIMEOUT_3       (512)
  ) i_dut (
    .i_clk                  (clk),
    .i_nrst                 (nrst),
    .i_sfr_addr             (addr),
    .i_sfr_wr               (wr),
    .i_sfr_rd               (rd),
    .i_sfr_wdata            (wdata),
    .o_sfr_rdata            (rdata),
    .i_supply_below_reset   (bsr),
    .i_supply_below_warning (bsw),
    .o_cpu_reset            (cpu_reset),
    .o_wdt_irq              (wdt_irq),
    .o_pfi_irq              (pfi_irq),
    .o_irq_vector           (vec),
    .o_bandgap_keep         (bg_keep)
  );

  supply_model i_supply (
    .i_clk           (clk),
    .o_below_reset   (bsr),
    .o_below_warning (bsw)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  function automatic int wd_limit(input int code);
    return 64 << code;
  endfunction

  task automatic finish_test;
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] dv);
    addr  = a;
    wdata = dv;
    wr    = 1'b1;
    @(posedge clk);
    #1;
    wr = 1'b0;
    @(posedge clk);
    #1;
  endtask

  task automatic sfr_rd(input logic [7:0] a, output logic [7:0] dv);
    addr = a;
    rd   = 1'b1;
    @(posedge clk);
    #1;
    rd = 1'b0;
    @(posedge clk);
    #1;
    dv = rdata;
  endtask

  task automatic ta_wr(input logic [7:0] a, input logic [7:0] dv);
    sfr_wr(8'hC7, 8'hAA);
    sfr_wr(8'hC7, 8'h55);
    sfr_wr(a, dv);
  endtask

  // 0 reset high, 1 reset low, 2 watchdog irq, 3 power-fail irq
  task automatic wait_for(input int w, input int lim, output int cnt);
    logic s;
    cnt = 0;
    s   = 1'b0;
    while (s !== 1'b1 && cnt < lim) begin
      @(posedge clk);
      #1;
      cnt++;
      case (w)
        0:       s = cpu_reset;
        1:       s = ~cpu_reset;
        2:       s = wdt_irq;
        default: s = pfi_irq;
      endcase
    end
    if (s !== 1'b1) begin
      num_errors++;
      $display("mismatch wait %0d expected 1 seen %b", w, s);
      finish_test();
    end
  endtask

  initial begin
    repeat (100000) @(posedge clk);
    num_errors++;
    finish_test();
  end

  initial begin
    seed = 19;
    nrst = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    num_errors = 0;
    tests_run = 0;
    repeat (4) @(posedge clk);
    #1;
    nrst = 1'b1;
    repeat (12) @(posedge clk);
    #1;
    chk("reset held", 16'h1, cpu_reset);
    i_supply.set_levels(1'b0, 1'b0);
    wait_for(1, 300, n);
    chk("stretch", 16'h1, 16'(n >= 16 && n <= 24));
    for (int i = 0; i < 5; i++) begin
      sfr_rd(ra[i], v);
      chk("reset value", rv[i], v);
    end
    // random traffic; protected bits must not move without the keys
    for (int i = 0; i < 8; i++) begin
      d = 8'($random(seed));
      sfr_wr(8'h8E, d);
      sfr_rd(8'h8E, v);
      chk("clock_control", d, v);
      sfr_wr(8'hE8, d);
      sfr_rd(8'hE8, v);
      chk("extended_irq_enable", d, v);
      sfr_wr(8'hD8, d & 8'hEB);
      sfr_rd(8'hD8, v);
      chk("watchdog_control", {2'b01, d[5], 5'h00}, v);
    end
    sfr_wr(8'h91, 8'h01);
    sfr_rd(8'h91, v);
    chk("bandgap open", 16'h00, v);
    ta_wr(8'h91, 8'h01);
    sfr_rd(8'h91, v);
    chk("bandgap", 16'h01, v);
    chk("bandgap keep", 16'h1, bg_keep);
    ta_wr(8'hD8, 8'h00);
    sfr_rd(8'hD8, v);
    chk("por flag clear", 16'h00, v);
    for (int k = 0; k < 4; k++) begin
      sfr_wr(8'hE8, 8'h10);
      sfr_wr(8'h8E, {k[1:0], 6'h01});
      ta_wr(8'hD8, 8'h03);
      wait_for(2, 2000, n);
      if (k == 0) begin
        off0 = n - wd_limit(0);
        chk("irq offset", 16'h0, 16'(off0));
      end
      chk("irq delay", 16'(wd_limit(k) + off0), 16'(n));
      wait_for(0, 700, m);
      chk("reset gap", 16'd512, 16'(m));
      wait_for(1, 100, m);
      sfr_rd(8'hD8, v);
      chk("watchdog_reset_flag", 16'h04, v & 8'h0E);
      sfr_wr(8'hD8, 8'h00);
    end
    // restart outside the window is ignored, inside it starts over
    sfr_wr(8'hE8, 8'h10);
    sfr_wr(8'h8E, 8'h01);
    ta_wr(8'hD8, 8'h03);
    repeat (40) @(posedge clk);
    #1;
    sfr_wr(8'hD8, 8'h03);
    wait_for(2, 200, n);
    chk("plain restart", 16'(64 + off0), 16'(n + 42));
    ta_wr(8'hD8, 8'h03);
    wait_for(2, 200, n);
    chk("restart delay", 16'(64 + off0), 16'(n));
    chk("wdt vector", 16'h0063, vec);
    chk("no reset", 16'h0, cpu_reset);
    i_supply.set_levels(1'b0, 1'b1);
    sfr_wr(8'hD8, 8'h20);
    wait_for(3, 20, n);
    chk("pfi vector", 16'h0033, vec);
    chk("wdt pending", 16'h1, wdt_irq);
    i_supply.set_levels(1'b0, 1'b0);
    repeat (6) @(posedge clk);
    #1;
    sfr_wr(8'hD8, 8'h20);
    chk("pfi cleared", 16'h0, pfi_irq);
    ta_wr(8'hD8, 8'h00);
    repeat (700) @(posedge clk);
    #1;
    sfr_rd(8'hD8, v);
    chk("disarmed", 16'h00, {cpu_reset, wdt_irq, v});
    i_supply.set_levels(1'b0, 1'b1);
    repeat (10) @(posedge clk);
    #1;
    sfr_rd(8'hD8, v);
    chk("pf flag", 16'h10, {pfi_irq, v});
    i_supply.set_levels(1'b0, 1'b0);
    repeat (6) @(posedge clk);
    #1;
    sfr_wr(8'hD8, 8'h00);
    sfr_rd(8'hD8, v);
    chk("pf flag clear", 16'h00, v);
    i_supply.set_levels(1'b1, 1'b1);
    repeat (30) @(posedge clk);
    #1;
    chk("brown-out", 16'h1, cpu_reset);
    i_supply.set_levels(1'b0, 1'b0);
    wait_for(1, 300, n);
    chk("restretch", 16'h1, 16'(n >= 16 && n <= 24));
    sfr_rd(8'hD8, v);
    chk("supply flags", 16'h40, v & 8'h46);
    finish_test();
  end
endmodule
